// ===== hw/online_edit_gate_and_trace.sv
// online edit gate, cycle time watchdog, output-off control and data trace
//
// Overview of operation
// - inhibit works only while key equals 5A
// - inhibited request waits pending, wait flag set
// - inhibit cleared: run held edit, swap flags
// - processing flag high while edit executes
// - inhibit during edit suspends it, wait set
// - request while pending is dropped, error reported
// - one-cycle inhibit: request served next cycle
// - edit overruns monitor time: fault and halt
// - edited block program restarts from first step
// - output-off forces all outputs off, indicator lit
// - output-off bit survives power cycle
// - periodic, per-scan or instruction sampling modes
// - 31 bits, 6 words per sample, 4000-word store
// - signed delay range shrinks with word count
// - positive delay stores later, negative earlier samples
// - per-scan sample taken after all tasks end
// - instruction sample only after trigger seen
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module online_edit_gate_and_trace
  import edit_trace_pkg::*;
#(
  parameter int MS_CYC = edit_trace_pkg::MS_CYCLES,
  parameter int WORD_W = 16,
  parameter int DEPTH  = edit_trace_pkg::TRACE_WORDS
) (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // edit requests from the programming tool
  input  wire logic        edit_req,
  input  wire logic        edit_done,
  input  wire logic        edit_has_block,
  output logic             edit_run,
  output logic             edit_error,
  output logic             block_restart,
  // scan cycle and operating mode
  input  wire logic        scan_end,
  input  wire logic        program_mode,
  output logic             cycle_over,
  // output-off control and its retained copy
  input  wire logic        output_off_saved,
  output logic             output_off_store,
  output logic             outputs_off,
  output logic             output_inhibit_indicator,
  // trace sources
  input  wire logic        trace_trigger,
  input  wire logic        trace_sample_instruction,
  input  wire logic [SAMPLE_BITS-1:0]              sample_bits,
  input  wire logic [MAX_SAMPLE_WORDS*WORD_W-1:0]  sample_words
);

  if (WORD_W != 16 || DEPTH > (1 << PTR_W) || MS_CYC < 1) begin : g_bad_param
    $error("online_edit_gate_and_trace: unsupported parameter values");
  end

  // ********************************************************
  // registers and bus
  // ********************************************************
  logic [7:0]   edit_inhibit_key;
  logic         edit_inhibit_bit;
  logic         edit_wait_flag;
  logic         edit_processing_flag;
  logic         err_sticky;
  logic         output_off;
  logic         restored;
  logic [15:0]  cycle_limit;
  logic [1:0]   trace_mode;
  logic [2:0]   nwords;
  logic         start_bit;
  logic [7:0]   period;
  logic [DELAY_W-1:0] delay;
  logic [PTR_W-1:0]   trace_addr;
  logic         rd_phase;
  logic         wr;
  logic         rd_go;
  logic         delay_bad;

  trace_state_t tstate;
  edit_state_t  estate;
  logic         trig_seen;
  logic [PTR_W-1:0] wptr;
  logic         over_ev;

  trace_mem_if #(.AW(PTR_W), .DW(WORD_W)) mem ();

  trace_store #(.DEPTH(DEPTH), .AW(PTR_W), .DW(WORD_W)) u_store (
    .clk_sys (clk_sys),
    .clk_en  (clk_en),
    .mem     (mem.store)
  );

  // reads wait one cycle so the trace store can answer; writes never wait
  assign rd_go           = avs_read & ~rd_phase;
  assign avs_waitrequest = rd_go;
  assign wr              = avs_write & clk_en;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rd_phase <= 1'b0;
    else if (clk_en)
      rd_phase <= rd_go;
  end

  // read data mux, loaded in the wait cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      avs_readdata <= 32'h0000_0000;
    else if (clk_en && rd_go)
    begin
      unique case (avs_address)
        REG_EDIT_CTRL:   avs_readdata <= {22'h0, edit_inhibit_bit, 1'b0, edit_inhibit_key};
        REG_EDIT_STAT:   avs_readdata <= {28'h0, err_sticky, cycle_over, edit_processing_flag, edit_wait_flag};
        REG_OUT_CTRL:    avs_readdata <= {31'h0, output_off};
        REG_CYCLE_LIMIT: avs_readdata <= {16'h0, cycle_limit};
        REG_TRACE_CTRL:  avs_readdata <= {16'h0, period, 2'h0, start_bit, nwords, trace_mode};
        REG_TRACE_DELAY: avs_readdata <= {20'h0, delay};
        REG_TRACE_STAT:  avs_readdata <= {4'h0, wptr, 12'h0, delay_bad, tstate == TR_DONE, trig_seen,
                                           tstate == TR_RUN};
        REG_TRACE_ADDR:  avs_readdata <= {20'h0, trace_addr};
        REG_TRACE_DATA:  avs_readdata <= {16'h0, mem.rd};
        default:         avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // plain control registers
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      edit_inhibit_key <= 8'h00;
      edit_inhibit_bit <= 1'b0;
      cycle_limit      <= RST_CYCLE_LIMIT;
      trace_mode       <= 2'h0;
      nwords           <= 3'h0;
      start_bit        <= 1'b0;
      period           <= RST_PERIOD;
      delay            <= '0;
      trace_addr       <= '0;
    end
    else if (wr)
    begin
      unique case (avs_address)
        REG_EDIT_CTRL:
        begin
          edit_inhibit_key <= avs_writedata[KEY_LSB +: 8];
          edit_inhibit_bit <= avs_writedata[INHIBIT_BIT];
        end
        REG_CYCLE_LIMIT: cycle_limit <= avs_writedata[15:0];
        REG_TRACE_CTRL:
        begin
          trace_mode <= avs_writedata[TC_MODE_LSB +: 2];
          nwords     <= (avs_writedata[TC_NW_LSB +: 3] > 3'd6) ? 3'd6 : avs_writedata[TC_NW_LSB +: 3];
          start_bit  <= avs_writedata[TC_START];
          period     <= avs_writedata[TC_PER_LSB +: 8];
        end
        REG_TRACE_DELAY: delay      <= avs_writedata[DELAY_W-1:0];
        REG_TRACE_ADDR:  trace_addr <= avs_writedata[PTR_W-1:0];
        default:         ;
      endcase
    end
  end

  // ********************************************************
  // output-off control
  // ********************************************************
  // restore retained value
  // reset clears it; the first enabled edge after release reloads the saved copy
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      output_off <= 1'b0;
      restored   <= 1'b0;
    end
    else if (clk_en)
    begin
      restored <= 1'b1;
      if (!restored)
        output_off <= output_off_saved;
      else if (wr && avs_address == REG_OUT_CTRL)
        output_off <= avs_writedata[OUTOFF_BIT];
    end
  end

  assign outputs_off              = output_off;
  assign output_inhibit_indicator = output_off;
  assign output_off_store         = output_off;

  // ********************************************************
  // millisecond time base
  // ********************************************************
  logic [31:0] ms_cnt;
  logic        ms_tick;

  assign ms_tick = (ms_cnt == 32'(MS_CYC - 1));

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      ms_cnt <= 32'h0;
    else if (clk_en)
      ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
  end

  // ********************************************************
  // edit gate
  // ********************************************************
  logic inhibit_eff;

  assign inhibit_eff = edit_inhibit_bit && (edit_inhibit_key == KEY_VALID);
  assign edit_run    = (estate == ED_PROC);
  assign edit_wait_flag       = (estate == ED_WAIT);
  assign edit_processing_flag = (estate == ED_PROC);

  // a request during an inhibited scan stays held, then runs once cleared
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      estate <= ED_IDLE;
    else if (clk_en)
    begin
      unique case (estate)
        ED_IDLE:
          if (edit_req)
            estate <= inhibit_eff ? ED_WAIT : ED_PROC;
        ED_WAIT:
          if (!inhibit_eff)
            estate <= ED_PROC;
        ED_PROC:
          if (inhibit_eff)
            estate <= ED_WAIT;
          else if (edit_done)
            estate <= ED_IDLE;
        default: estate <= ED_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      edit_error <= 1'b0;
      err_sticky <= 1'b0;
    end
    else if (clk_en)
    begin
      edit_error <= edit_req && estate == ED_WAIT;
      // set wins over the write-one clear
      if (edit_req && estate == ED_WAIT)
        err_sticky <= 1'b1;
      else if (wr && avs_address == REG_EDIT_STAT && avs_writedata[ST_ERR])
        err_sticky <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      block_restart <= 1'b0;
    else if (clk_en)
      block_restart <= estate == ED_PROC && !inhibit_eff && edit_done && edit_has_block;
  end

  // ********************************************************
  // cycle time watchdog
  // ********************************************************
  logic [15:0] scan_ms;
  logic        edit_in_scan;

  // scan length in ms, saturating; edits mark the scan they touch
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      scan_ms      <= 16'h0;
      edit_in_scan <= 1'b0;
    end
    else if (clk_en)
    begin
      if (scan_end)
        scan_ms <= 16'h0;
      else if (ms_tick && scan_ms != 16'hFFFF)
        scan_ms <= scan_ms + 16'h1;
      edit_in_scan <= (estate == ED_PROC) || (edit_in_scan && !scan_end);
    end
  end

  assign over_ev = edit_in_scan && cycle_limit != 16'h0 && scan_ms > cycle_limit;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      cycle_over <= 1'b0;
    else if (clk_en)
    begin
      if (over_ev)
        cycle_over <= 1'b1;
      else if (program_mode)
        cycle_over <= 1'b0;
    end
  end

  // ********************************************************
  // data trace
  // ********************************************************
  // samples held in the store for n sampled words
  function automatic logic [PTR_W-1:0] cap_of(input logic [2:0] n);
    cap_of = PTR_W'(DEPTH / (int'(n) + FRAME_BIT_WORDS));
  endfunction

  // k-th word of a sample frame: two bit words, then the selected words
  function automatic logic [WORD_W-1:0] frame_word(input logic [2:0] k,
                                                   input logic [SAMPLE_BITS-1:0] b,
                                                   input logic [MAX_SAMPLE_WORDS*WORD_W-1:0] w);
    if (k == 3'd0)
      frame_word = b[15:0];
    else if (k == 3'd1)
      frame_word = {1'b0, b[30:16]};
    else
      frame_word = w[(int'(k) - FRAME_BIT_WORDS) * WORD_W +: WORD_W];
  endfunction

  logic [PTR_W-1:0] cap;
  logic [PTR_W-1:0] ring_len;
  logic signed [12:0] dly;
  logic signed [12:0] cap13;
  logic [12:0]      target;
  logic [12:0]      post_cnt;
  logic [11:0]      per_ms;
  logic             per_hit;
  logic             sample_req;
  logic             busy;
  logic [2:0]       k;
  logic             start_q;
  logic [SAMPLE_BITS-1:0]             snap_bits;
  logic [MAX_SAMPLE_WORDS*WORD_W-1:0] snap_words;

  assign cap      = cap_of(nwords);
  assign ring_len = PTR_W'(cap * (nwords + 3'd2));
  assign dly      = {delay[DELAY_W-1], delay};
  assign cap13    = {1'b0, cap};
  assign delay_bad = dly > cap13 || dly < 13'sd1 - cap13;
  assign target   = 13'(cap13 + dly);

  // period counter in ms; a zero period never fires
  assign per_hit = ms_tick && period != 8'h00 && per_ms == 12'(period * PERIOD_UNIT_MS - 1);

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      per_ms <= 12'h0;
    else if (clk_en && ms_tick)
      per_ms <= per_hit ? 12'h0 : per_ms + 12'h1;
  end

  always_comb
  begin
    unique case (trace_mode)
      TM_PERIOD: sample_req = per_hit;
      TM_SCAN:   sample_req = scan_end;
      TM_INSTR:  sample_req = trace_sample_instruction && trig_seen;
      default:   sample_req = 1'b0;
    endcase
  end

  assign mem.we = busy;
  assign mem.wa = wptr;
  assign mem.wd = frame_word(k, snap_bits, snap_words);
  assign mem.ra = trace_addr;

  // start on a rising start bit with a legal delay; dropping it ends the trace
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      tstate    <= TR_IDLE;
      start_q   <= 1'b0;
      trig_seen <= 1'b0;
      busy      <= 1'b0;
      k         <= 3'h0;
      wptr      <= '0;
      post_cnt  <= 13'h0;
      snap_bits <= '0;
      snap_words <= '0;
    end
    else if (clk_en)
    begin
      start_q <= start_bit;
      unique case (tstate)
        TR_IDLE:
          if (start_bit && !start_q && !delay_bad)
          begin
            tstate    <= TR_RUN;
            trig_seen <= 1'b0;
            wptr      <= '0;
            post_cnt  <= 13'h0;
          end
        TR_RUN:
        begin
          if (trace_trigger)
            trig_seen <= 1'b1;
          if (!busy && sample_req)
          begin
            busy       <= 1'b1;
            k          <= 3'h0;
            snap_bits  <= sample_bits;
            snap_words <= sample_words;
          end
          if (busy)
          begin
            wptr <= (wptr == ring_len - 1'b1) ? '0 : wptr + 1'b1;
            k    <= k + 3'h1;
            if (k == nwords + 3'd1)
            begin
              busy <= 1'b0;
              if (trig_seen)
              begin
                post_cnt <= post_cnt + 13'h1;
                if (post_cnt + 13'h1 == target)
                  tstate <= TR_DONE;
              end
            end
          end
          if (!start_bit)
          begin
            tstate <= TR_IDLE;
            busy   <= 1'b0;
          end
        end
        TR_DONE:
          if (!start_bit)
            tstate <= TR_IDLE;
        default: tstate <= TR_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== hw/edit_trace_pkg.sv
// constants, field layout and state types of the edit gate and trace block
package edit_trace_pkg;
  // timing
  localparam int CLK_PERIOD_NS   = 5;
  localparam int MS_NS           = 1000000;
  localparam int MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
  localparam int PERIOD_UNIT_MS  = 10;
  // register byte offsets
  localparam logic [5:0] REG_EDIT_CTRL   = 6'h00;
  localparam logic [5:0] REG_EDIT_STAT   = 6'h04;
  localparam logic [5:0] REG_OUT_CTRL    = 6'h08;
  localparam logic [5:0] REG_CYCLE_LIMIT = 6'h0C;
  localparam logic [5:0] REG_TRACE_CTRL  = 6'h10;
  localparam logic [5:0] REG_TRACE_DELAY = 6'h14;
  localparam logic [5:0] REG_TRACE_STAT  = 6'h18;
  localparam logic [5:0] REG_TRACE_ADDR  = 6'h1C;
  localparam logic [5:0] REG_TRACE_DATA  = 6'h20;
  // field positions
  localparam int KEY_LSB      = 0;
  localparam int INHIBIT_BIT  = 9;
  localparam int ST_WAIT      = 0;
  localparam int ST_PROC      = 1;
  localparam int ST_OVER      = 2;
  localparam int ST_ERR       = 3;
  localparam int OUTOFF_BIT   = 0;
  localparam int TC_MODE_LSB  = 0;
  localparam int TC_NW_LSB    = 2;
  localparam int TC_START     = 5;
  localparam int TC_PER_LSB   = 8;
  localparam int TS_RUN       = 0;
  localparam int TS_TRIG      = 1;
  localparam int TS_DONE      = 2;
  localparam int TS_BADDLY    = 3;
  localparam int TS_PTR_LSB   = 16;
  // values and sizes
  localparam logic [7:0]  KEY_VALID        = 8'h5A;
  localparam logic [15:0] RST_CYCLE_LIMIT  = 16'h03E8;
  localparam logic [7:0]  RST_PERIOD       = 8'h01;
  localparam int TRACE_WORDS      = 4000;
  localparam int MAX_SAMPLE_WORDS = 6;
  localparam int SAMPLE_BITS      = 31;
  localparam int FRAME_BIT_WORDS  = 2;
  localparam int DELAY_W          = 12;
  localparam int PTR_W            = 12;
  // states and modes
  typedef enum logic [1:0] {TM_PERIOD, TM_SCAN, TM_INSTR} trace_mode_t;
  typedef enum logic [1:0] {ED_IDLE, ED_WAIT, ED_PROC} edit_state_t;
  typedef enum logic [1:0] {TR_IDLE, TR_RUN, TR_DONE} trace_state_t;
endpackage

// ===== hw/trace_mem_if.sv
// write and read port bundle between the trace control and its store
`timescale 1ns/10ps
`default_nettype none
interface trace_mem_if #(parameter int AW = 12, parameter int DW = 16);
  logic          we;
  logic [AW-1:0] wa;
  logic [DW-1:0] wd;
  logic [AW-1:0] ra;
  logic [DW-1:0] rd;
  modport ctrl  (output we, output wa, output wd, output ra, input rd);
  modport store (input we, input wa, input wd, input ra, output rd);
endinterface
`default_nettype wire

// ===== hw/trace_store.sv
// trace memory: one write port, one registered read port
`timescale 1ns/10ps
`default_nettype none
module trace_store #(
  parameter int DEPTH = 4000,
  parameter int AW    = 12,
  parameter int DW    = 16
) (
  // clock
  input  wire logic clk_sys,
  input  wire logic clk_en,
  // memory ports
  trace_mem_if.store mem
);
  logic [DW-1:0] cells [DEPTH];

  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("trace_store depth exceeds address range");
  end

  // contents are not reset; reads show stale data until written
  always_ff @(posedge clk_sys)
  begin
    if (clk_en)
    begin
      if (mem.we)
        cells[mem.wa] <= mem.wd;
      mem.rd <= cells[mem.ra];
    end
  end
endmodule
`default_nettype wire

// ===== verif/edit_tool_model.sv
// behavioural model of the programming tool that drives edit requests
`timescale 1ns/10ps
`default_nettype none
module edit_tool_model (
  // clock
  input  wire logic clk_sys,
  // edit handshake and operating mode
  output var  logic edit_req,
  output var  logic edit_done,
  output var  logic program_mode
);
  // ****
  // tool actions, each called just after a rising edge
  // ****
  initial
  begin
    edit_req     = 1'b0;
    edit_done    = 1'b0;
    program_mode = 1'b0;
  end
  // one-cycle request, taken at the next edge
  task automatic pulse_req();
    edit_req <= 1'b1;
    @(posedge clk_sys);
    edit_req <= 1'b0;
  endtask
  // end of the running edit
  task automatic pulse_done();
    edit_done <= 1'b1;
    @(posedge clk_sys);
    edit_done <= 1'b0;
  endtask
  task automatic set_prog(input logic v);
    program_mode <= v;
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ===== verif/online_edit_gate_and_trace_sva.sv
// assertion checker for the edit gate top ports
`timescale 1ns/10ps
`default_nettype none
module edit_gate_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clk_en,
  // bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // edit gate and watchdog
  input wire logic edit_req,
  input wire logic edit_done,
  input wire logic edit_has_block,
  input wire logic edit_run,
  input wire logic edit_error,
  input wire logic block_restart,
  input wire logic program_mode,
  input wire logic cycle_over,
  // output-off
  input wire logic output_off_store,
  input wire logic outputs_off,
  input wire logic output_inhibit_indicator
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  a_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was stalled");
  a_read_onewait: assert property (avs_read && avs_waitrequest && clk_en |=> !avs_waitrequest)
    else $error("read waited more than one cycle");
  a_error_cause: assert property (edit_error |-> $past(edit_req))
    else $error("edit error without a request");
  a_restart_cause: assert property (block_restart |-> $past(edit_done) && $past(edit_has_block))
    else $error("block restart without a finished block edit");
  a_restart_idle: assert property (block_restart |-> !edit_run)
    else $error("processing still on after the edit finished");
  a_over_hold: assert property (cycle_over && !program_mode && clk_en |=> cycle_over)
    else $error("fault left without program mode");
  a_off_lamp: assert property (outputs_off == output_inhibit_indicator)
    else $error("indicator differs from output-off");
  a_off_kept: assert property (output_off_store == outputs_off)
    else $error("retained copy differs from output-off");
  // main scenarios reached
  c_restart: cover property (block_restart);
  c_error: cover property (edit_error);
  c_over: cover property (cycle_over);
endmodule
bind online_edit_gate_and_trace edit_gate_checker u_chk (.clk_sys, .rstn, .clk_en, .avs_read, .avs_write,
  .avs_waitrequest, .edit_req, .edit_done, .edit_has_block, .edit_run, .edit_error, .block_restart,
  .program_mode, .cycle_over, .output_off_store, .outputs_off, .output_inhibit_indicator);
`default_nettype wire

// ===== verif/test_online_edit_gate_and_trace.sv
// self-checking bench for the edit gate and trace block
`timescale 1ns/10ps
`default_nettype none
module test_online_edit_gate_and_trace;
  import edit_trace_pkg::*;
  logic                   clk_sys, rstn, clk_en, avs_read, avs_write, avs_waitrequest;
  logic [5:0]             avs_address;
  logic [31:0]            avs_writedata, avs_readdata, q;
  logic                   edit_req, edit_done, edit_has_block, edit_run, edit_error, block_restart;
  logic                   scan_end, program_mode, cycle_over, output_off_saved, output_off_store;
  logic                   outputs_off, output_inhibit_indicator, trace_trigger, trace_sample_instruction;
  logic [SAMPLE_BITS-1:0] sample_bits;
  logic [95:0]            sample_words;
  int                     miscompares, comparisons, cycles;
  online_edit_gate_and_trace #(.MS_CYC(10)) DUT (.clk_sys, .rstn, .clk_en, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .edit_req, .edit_done, .edit_has_block,
    .edit_run, .edit_error, .block_restart, .scan_end, .program_mode, .cycle_over, .output_off_saved,
    .output_off_store, .outputs_off, .output_inhibit_indicator, .trace_trigger, .trace_sample_instruction,
    .sample_bits, .sample_words);
  edit_tool_model tool (.clk_sys, .edit_req, .edit_done, .program_mode);
  // ****
  // clock, timeout and shared tasks
  // ****
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // a hung handshake ends the run here
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one bus transfer; an idle edge follows so requests never retoggle in one step
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(negedge clk_sys); while (avs_waitrequest !== 1'b0);
    @(posedge clk_sys);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask
  // bounded wait for a level or a one-cycle pulse, judged mid-cycle
  task automatic waitv(ref logic s, input logic v, input string nm);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (s !== v && n < 100);
    chk(nm, {31'h0, v}, {31'h0, s});
    @(posedge clk_sys);
  endtask
  task automatic scan_pulse();
    scan_end <= 1'b1;
    @(posedge clk_sys);
    scan_end <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic instr_pulse();
    trace_sample_instruction <= 1'b1;
    @(posedge clk_sys);
    trace_sample_instruction <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_off();
    bus(REG_OUT_CTRL, 1'b1, 32'h1);
    waitv(output_inhibit_indicator, 1'b1, "indicator");
    chk("outputs off", 32'h1, {31'h0, outputs_off});
    output_off_saved <= 1'b1;
    rstn             <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    waitv(outputs_off, 1'b1, "kept off");
    chk("store", 32'h1, {31'h0, output_off_store});
    output_off_saved <= 1'b0;
    bus(REG_OUT_CTRL, 1'b1, 32'h0);
  endtask
  task automatic t_regs();
    bus(REG_CYCLE_LIMIT, 1'b0, 32'h0);
    chk("limit", 32'h3E8, q);
    bus(REG_TRACE_CTRL, 1'b0, 32'h0);
    chk("trace ctrl", 32'h100, q);
    bus(6'h3C, 1'b0, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(REG_EDIT_STAT, 1'b1, 32'h7);
    bus(REG_EDIT_CTRL, 1'b1, 32'h25A);
    bus(REG_EDIT_CTRL, 1'b0, 32'h0);
    chk("edit ctrl", 32'h25A, q);
    bus(REG_EDIT_STAT, 1'b0, 32'h0);
    chk("stat ro", 32'h0, q & 32'h7);
  endtask
  task automatic t_gate();
    tool.pulse_req();
    bus(REG_EDIT_STAT, 1'b0, 32'h0);
    chk("waiting", 32'h1, q & 32'h3);
    tool.pulse_req();
    waitv(edit_error, 1'b1, "error pulse");
    bus(REG_EDIT_STAT, 1'b0, 32'h0);
    chk("dropped", 32'h9, q & 32'hB);
    bus(REG_EDIT_CTRL, 1'b1, 32'h5A);
    bus(REG_EDIT_STAT, 1'b0, 32'h0);
    chk("resumed", 32'h2, q & 32'h3);
    edit_has_block <= 1'b1;
    tool.pulse_done();
    waitv(block_restart, 1'b1, "restart");
    chk("finished", 32'h0, {31'h0, edit_run});
    edit_has_block <= 1'b0;
  endtask
  task automatic t_suspend();
    bus(REG_EDIT_CTRL, 1'b1, 32'h233);
    tool.pulse_req();
    waitv(edit_run, 1'b1, "bad key");
    bus(REG_EDIT_CTRL, 1'b1, 32'h25A);
    bus(REG_EDIT_STAT, 1'b0, 32'h0);
    chk("suspended", 32'h1, q & 32'h3);
    bus(REG_EDIT_CTRL, 1'b1, 32'h0);
    waitv(edit_run, 1'b1, "next cycle");
    tool.pulse_done();
  endtask
  task automatic t_over();
    scan_pulse();
    bus(REG_CYCLE_LIMIT, 1'b1, 32'h1);
    tool.pulse_req();
    waitv(cycle_over, 1'b1, "overrun");
    tool.pulse_done();
    scan_pulse();
    tool.set_prog(1'b1);
    waitv(cycle_over, 1'b0, "program mode");
    tool.set_prog(1'b0);
  endtask
  task automatic t_trace();
    logic [31:0] p;
    bus(REG_TRACE_CTRL, 1'b1, 32'h122);
    bus(REG_TRACE_STAT, 1'b0, 32'h0);
    p = q;
    instr_pulse();
    bus(REG_TRACE_STAT, 1'b0, 32'h0);
    chk("no trigger", p & 32'hFFF0000, q & 32'hFFF0000);
    trace_trigger <= 1'b1;
    @(posedge clk_sys);
    instr_pulse();
    bus(REG_TRACE_STAT, 1'b0, 32'h0);
    chk("instr frame", 32'(p[27:16] + 12'd2), 32'(q[27:16]));
    trace_trigger <= 1'b0;
    bus(REG_TRACE_CTRL, 1'b1, 32'h100);
    bus(REG_TRACE_CTRL, 1'b1, 32'h121);
    bus(REG_TRACE_STAT, 1'b0, 32'h0);
    p = q;
    scan_pulse();
    bus(REG_TRACE_STAT, 1'b0, 32'h0);
    chk("scan frame", 32'(p[27:16] + 12'd2), 32'(q[27:16]));
  endtask
  // start with a given word count and delay, mode cycling through all three
  task automatic try_dly(input int n, input int d, input logic bad);
    bus(REG_TRACE_CTRL, 1'b1, 32'h100 | 32'(n << TC_NW_LSB));
    bus(REG_TRACE_DELAY, 1'b1, 32'(d) & 32'hFFF);
    bus(REG_TRACE_CTRL, 1'b1, 32'h120 | 32'(n << TC_NW_LSB) | 32'(n % 3));
    bus(REG_TRACE_STAT, 1'b0, 32'h0);
    chk("delay range", bad ? 32'h8 : 32'h1, q & 32'h9);
  endtask
  task automatic t_delay();
    int mx[7] = '{2000, 1333, 1000, 800, 666, 571, 500};
    for (int n = 0; n < 7; n++)
    begin
      try_dly(n, mx[n], 1'b0);
      try_dly(n, mx[n] + 1, 1'b1);
      try_dly(n, 1 - mx[n], 1'b0);
      try_dly(n, -mx[n], 1'b1);
    end
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    rstn                     = 1'b0;
    clk_en                   = 1'b1;
    avs_address              = 6'h00;
    avs_read                 = 1'b0;
    avs_write                = 1'b0;
    avs_writedata            = 32'h0;
    edit_has_block           = 1'b0;
    scan_end                 = 1'b0;
    output_off_saved         = 1'b0;
    trace_trigger            = 1'b0;
    trace_sample_instruction = 1'b0;
    sample_bits              = 31'h2AAA5555;
    sample_words             = 96'hC3C3_1234_5678_9ABC_DEF0_0F0F;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_off();
    t_regs();
    t_gate();
    t_suspend();
    t_over();
    t_trace();
    t_delay();
    end_sim();
  end
endmodule
`default_nettype wire
